// *** sopc_defs.vh ***
`ifndef SOPC_DEFS_VH
`define SOPC_DEFS_VH

// register indexes; byte address is four times the index
`define SOPC_IDX_OUTPUT_CONTROL 8'h4c
`define SOPC_IDX_LEFT2_VOLUME 8'h6a
`define SOPC_IDX_RIGHT2_VOLUME 8'h6b
`define SOPC_IDX_BEEP_VOLUME 8'h6f
`define SOPC_IDX_PAIR_STATUS 8'h70

// shared volume register fields
`define SOPC_MUTE_BIT 14
`define SOPC_ZC_BIT 13
`define SOPC_VU_BIT 8
`define SOPC_GAIN_LSB 2
`define SOPC_GAIN_MSB 7

// right volume register extras
`define SOPC_INV_EN_BIT 10
`define SOPC_INV_BYPASS_BIT 9

// output control
`define SOPC_FB_BIT 2

// beep register
`define SOPC_BEEP_EN_BIT 15
`define SOPC_BEEP_GAIN_LSB 5
`define SOPC_BEEP_GAIN_MSB 7

// status register layout
`define SOPC_ST_LGAIN_LSB 0
`define SOPC_ST_RGAIN_LSB 8
`define SOPC_ST_LPEND_BIT 14
`define SOPC_ST_RPEND_BIT 15

// reset values
`define SOPC_GAIN_RST 6'h39
`define SOPC_INV_EN_RST 1'h0
`define SOPC_INV_BYPASS_RST 1'h1
`define SOPC_BEEP_GAIN_RST 3'h0

`endif

// *** sopc_gain_apply.v ***
`timescale 1ns/1ps
// ==========================================================
// one channel: stored gain code moves to the amplifier
module sopc_gain_apply #(
  parameter WIDTH = 6,
  parameter [5:0] RESET_CODE = 6'h39
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // control
  input wire [WIDTH-1:0] stored_code,
  input wire update,
  input wire zc_en,
  input wire zero_cross,
  // result
  output reg [WIDTH-1:0] applied_code,
  output reg pending
);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      applied_code <= RESET_CODE[WIDTH-1:0];
      pending <= 1'b0;
    end else if (update && !zc_en) begin
      applied_code <= stored_code;
      pending <= 1'b0;
    end else if (update) begin
      // a new update restarts the wait for the next crossing
      pending <= 1'b1;
    end else if (pending && (zero_cross || !zc_en)) begin
      // clearing the enable while waiting releases the change at once
      applied_code <= stored_code;
      pending <= 1'b0;
    end
  end

endmodule

// *** sopc_regs.v ***
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sopc_defs.vh"

module sopc_regs #(
  parameter ADDR_WIDTH = 10,
  parameter GAIN_WIDTH = 6,
  parameter BEEP_WIDTH = 3
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // avalon-mm slave
  input wire [ADDR_WIDTH-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // zero-cross comparators, asynchronous
  input wire left_signal_sign,
  input wire right_signal_sign,
  // left amplifier controls
  output reg [GAIN_WIDTH-1:0] second_left_output_gain,
  output reg second_left_output_mute,
  // right amplifier controls
  output reg [GAIN_WIDTH-1:0] second_right_output_gain,
  output reg second_right_output_mute,
  output reg right_inverter_en_out,
  output reg right_inverter_bypass_out,
  // common return and beep path
  output reg pair_ground_feedback_out,
  output reg beep_mix_out,
  output reg [BEEP_WIDTH-1:0] beep_gain_out
);

  // ==========================================================
  // stored fields
  reg [GAIN_WIDTH-1:0] left_gain_code;
  reg [GAIN_WIDTH-1:0] right_gain_code;
  reg left_zero_cross_en;
  reg right_zero_cross_en;
  reg left_channel_mute;
  reg right_channel_mute;
  reg right_inverter_en;
  reg right_inverter_bypass;
  reg pair_ground_feedback_en;
  reg beep_mix_en;
  reg [BEEP_WIDTH-1:0] beep_gain_code;
  reg pair_volume_update;

  // ==========================================================
  // bus decode
  reg access_done;
  wire request;
  wire take;
  wire [7:0] reg_index;
  wire word_aligned;
  wire [15:0] wdata;
  wire lo_en;
  wire hi_en;

  assign request = avs_read | avs_write;
  // one wait cycle: the edge that drops waitrequest also commits the access
  assign take = request & avs_waitrequest & ~access_done;
  assign reg_index = avs_address[9:2];
  assign word_aligned = (avs_address[1:0] == 2'h0);
  assign wdata = avs_writedata[15:0];
  assign lo_en = avs_byteenable[0];
  assign hi_en = avs_byteenable[1];

  function hit;
    input [7:0] idx;
    input [7:0] target;
    input aligned;
    begin
      hit = aligned && (idx == target);
    end
  endfunction

  wire wr_take;
  wire sel_out_ctl;
  wire sel_left;
  wire sel_right;
  wire sel_beep;
  wire sel_status;

  assign wr_take = take & avs_write;
  assign sel_out_ctl = hit(reg_index, `SOPC_IDX_OUTPUT_CONTROL, word_aligned);
  assign sel_left = hit(reg_index, `SOPC_IDX_LEFT2_VOLUME, word_aligned);
  assign sel_right = hit(reg_index, `SOPC_IDX_RIGHT2_VOLUME, word_aligned);
  assign sel_beep = hit(reg_index, `SOPC_IDX_BEEP_VOLUME, word_aligned);
  assign sel_status = hit(reg_index, `SOPC_IDX_PAIR_STATUS, word_aligned);

  // ==========================================================
  // waitrequest handshake
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      access_done <= 1'b0;
    end else begin
      if (take) begin
        avs_waitrequest <= 1'b0;
        access_done <= 1'b1;
      end else begin
        avs_waitrequest <= 1'b1;
        access_done <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register writes
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_gain_code <= `SOPC_GAIN_RST;
      right_gain_code <= `SOPC_GAIN_RST;
      left_zero_cross_en <= 1'b0;
      right_zero_cross_en <= 1'b0;
      left_channel_mute <= 1'b0;
      right_channel_mute <= 1'b0;
      right_inverter_en <= `SOPC_INV_EN_RST;
      right_inverter_bypass <= `SOPC_INV_BYPASS_RST;
      pair_ground_feedback_en <= 1'b0;
      beep_mix_en <= 1'b0;
      beep_gain_code <= `SOPC_BEEP_GAIN_RST;
      pair_volume_update <= 1'b0;
    end else begin
      pair_volume_update <= 1'b0;
      if (wr_take && sel_out_ctl && lo_en) begin
        pair_ground_feedback_en <= wdata[`SOPC_FB_BIT];
      end
      if (wr_take && sel_left) begin
        if (lo_en) begin
          left_gain_code <= wdata[`SOPC_GAIN_MSB:`SOPC_GAIN_LSB];
        end
        if (hi_en) begin
          left_zero_cross_en <= wdata[`SOPC_ZC_BIT];
          left_channel_mute <= wdata[`SOPC_MUTE_BIT];
          pair_volume_update <= wdata[`SOPC_VU_BIT];
        end
      end
      if (wr_take && sel_right) begin
        if (lo_en) begin
          right_gain_code <= wdata[`SOPC_GAIN_MSB:`SOPC_GAIN_LSB];
        end
        if (hi_en) begin
          right_zero_cross_en <= wdata[`SOPC_ZC_BIT];
          right_channel_mute <= wdata[`SOPC_MUTE_BIT];
          right_inverter_en <= wdata[`SOPC_INV_EN_BIT];
          right_inverter_bypass <= wdata[`SOPC_INV_BYPASS_BIT];
          pair_volume_update <= wdata[`SOPC_VU_BIT];
        end
      end
      if (wr_take && sel_beep) begin
        if (lo_en) begin
          beep_gain_code <= wdata[`SOPC_BEEP_GAIN_MSB:`SOPC_BEEP_GAIN_LSB];
        end
        if (hi_en) begin
          beep_mix_en <= wdata[`SOPC_BEEP_EN_BIT];
        end
      end
    end
  end

  // ==========================================================
  // zero-cross detection
  reg [2:0] left_sign_sync;
  reg [2:0] right_sign_sync;
  wire left_crossed;
  wire right_crossed;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_sign_sync <= 3'h0;
      right_sign_sync <= 3'h0;
    end else begin
      left_sign_sync <= {left_sign_sync[1:0], left_signal_sign};
      right_sign_sync <= {right_sign_sync[1:0], right_signal_sign};
    end
  end

  // stage 0 feeds only stage 1; the edge is seen between stages 1 and 2
  assign left_crossed = left_sign_sync[2] ^ left_sign_sync[1];
  assign right_crossed = right_sign_sync[2] ^ right_sign_sync[1];

  // ==========================================================
  // gain application, both channels on the shared update strobe
  wire [GAIN_WIDTH-1:0] left_applied;
  wire [GAIN_WIDTH-1:0] right_applied;
  wire left_pending;
  wire right_pending;

  sopc_gain_apply #(
    .WIDTH(GAIN_WIDTH),
    .RESET_CODE(`SOPC_GAIN_RST)
  ) left_apply (
    .mclk(mclk),
    .rst_n(rst_n),
    .stored_code(left_gain_code),
    .update(pair_volume_update),
    .zc_en(left_zero_cross_en),
    .zero_cross(left_crossed),
    .applied_code(left_applied),
    .pending(left_pending)
  );

  sopc_gain_apply #(
    .WIDTH(GAIN_WIDTH),
    .RESET_CODE(`SOPC_GAIN_RST)
  ) right_apply (
    .mclk(mclk),
    .rst_n(rst_n),
    .stored_code(right_gain_code),
    .update(pair_volume_update),
    .zc_en(right_zero_cross_en),
    .zero_cross(right_crossed),
    .applied_code(right_applied),
    .pending(right_pending)
  );

  // ==========================================================
  // amplifier control outputs, all registered
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      second_left_output_gain <= `SOPC_GAIN_RST;
      second_right_output_gain <= `SOPC_GAIN_RST;
      second_left_output_mute <= 1'b0;
      second_right_output_mute <= 1'b0;
      right_inverter_en_out <= `SOPC_INV_EN_RST;
      right_inverter_bypass_out <= `SOPC_INV_BYPASS_RST;
      pair_ground_feedback_out <= 1'b0;
      beep_mix_out <= 1'b0;
      beep_gain_out <= `SOPC_BEEP_GAIN_RST;
    end else begin
      second_left_output_gain <= left_applied;
      second_right_output_gain <= right_applied;
      second_left_output_mute <= left_channel_mute;
      // mute sits after the polarity choice so it covers both paths
      second_right_output_mute <= right_channel_mute;
      // polarity pair is passed as written; other combinations are not checked
      right_inverter_en_out <= right_inverter_en;
      right_inverter_bypass_out <= right_inverter_bypass;
      pair_ground_feedback_out <= pair_ground_feedback_en;
      // beep not gated by polarity: software keeps the inverting path selected
      beep_mix_out <= beep_mix_en;
      beep_gain_out <= beep_gain_code;
    end
  end

  // ==========================================================
  // read data
  reg [15:0] next_rdata;

  always @* begin
    next_rdata = 16'h0000;
    if (sel_out_ctl) begin
      next_rdata[`SOPC_FB_BIT] = pair_ground_feedback_en;
    end else if (sel_left) begin
      next_rdata[`SOPC_MUTE_BIT] = left_channel_mute;
      next_rdata[`SOPC_ZC_BIT] = left_zero_cross_en;
      next_rdata[`SOPC_GAIN_MSB:`SOPC_GAIN_LSB] = left_gain_code;
    end else if (sel_right) begin
      next_rdata[`SOPC_MUTE_BIT] = right_channel_mute;
      next_rdata[`SOPC_ZC_BIT] = right_zero_cross_en;
      next_rdata[`SOPC_INV_EN_BIT] = right_inverter_en;
      next_rdata[`SOPC_INV_BYPASS_BIT] = right_inverter_bypass;
      next_rdata[`SOPC_GAIN_MSB:`SOPC_GAIN_LSB] = right_gain_code;
    end else if (sel_beep) begin
      next_rdata[`SOPC_BEEP_EN_BIT] = beep_mix_en;
      next_rdata[`SOPC_BEEP_GAIN_MSB:`SOPC_BEEP_GAIN_LSB] = beep_gain_code;
    end else if (sel_status) begin
      next_rdata[`SOPC_ST_LGAIN_LSB+5:`SOPC_ST_LGAIN_LSB] = left_applied;
      next_rdata[`SOPC_ST_RGAIN_LSB+5:`SOPC_ST_RGAIN_LSB] = right_applied;
      next_rdata[`SOPC_ST_LPEND_BIT] = left_pending;
      next_rdata[`SOPC_ST_RPEND_BIT] = right_pending;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (take && avs_read) begin
      avs_readdata <= {16'h0000, next_rdata};
    end
  end

endmodule

// *** sopc_regs_sva.sv ***
`timescale 1ns/1ps
`include "sopc_defs.vh"
// ==========================================================
// checker
module sopc_regs_sva #(
  parameter ADDR_WIDTH = 10,
  parameter GAIN_WIDTH = 6,
  parameter BEEP_WIDTH = 3
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // bus
  input wire [ADDR_WIDTH-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // zero-cross inputs
  input wire left_signal_sign,
  input wire right_signal_sign,
  // amplifier controls
  input wire [GAIN_WIDTH-1:0] second_left_output_gain,
  input wire second_left_output_mute,
  input wire [GAIN_WIDTH-1:0] second_right_output_gain,
  input wire second_right_output_mute,
  input wire right_inverter_en_out,
  input wire right_inverter_bypass_out,
  input wire pair_ground_feedback_out,
  input wire beep_mix_out,
  input wire [BEEP_WIDTH-1:0] beep_gain_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // accepted write to one register lane
  sequence s_wr(idx, lane);
    avs_write && !avs_waitrequest && avs_byteenable[lane] && avs_address == {idx, 2'b00};
  endsequence
  // field reaches its output one edge after the master sees acceptance
  property p_fld(idx, lane, d, o);
    logic [3:0] v;
    (s_wr(idx, lane), v = d) |-> ##1 (o == v);
  endproperty
  chk_left_mute: assert property (p_fld(`SOPC_IDX_LEFT2_VOLUME, 1, avs_writedata[14], second_left_output_mute)) else $error("left mute not applied");
  chk_right_mute: assert property (p_fld(`SOPC_IDX_RIGHT2_VOLUME, 1, avs_writedata[14], second_right_output_mute)) else $error("right mute not applied");
  chk_inv_enable: assert property (p_fld(`SOPC_IDX_RIGHT2_VOLUME, 1, avs_writedata[10], right_inverter_en_out)) else $error("inverter enable wrong");
  chk_inv_bypass: assert property (p_fld(`SOPC_IDX_RIGHT2_VOLUME, 1, avs_writedata[9], right_inverter_bypass_out)) else $error("inverter bypass wrong");
  chk_ground_fb: assert property (p_fld(`SOPC_IDX_OUTPUT_CONTROL, 0, avs_writedata[2], pair_ground_feedback_out)) else $error("feedback enable wrong");
  chk_beep_mix: assert property (p_fld(`SOPC_IDX_BEEP_VOLUME, 1, avs_writedata[15], beep_mix_out)) else $error("beep enable wrong");
  chk_beep_gain: assert property (p_fld(`SOPC_IDX_BEEP_VOLUME, 0, avs_writedata[7:5], beep_gain_out)) else $error("beep gain wrong");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest) else $error("no answer");
  chk_rd_upper: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0) else $error("upper read bits set");
  chk_reset_vals: assert property ($rose(rst_n) |-> second_left_output_gain == `SOPC_GAIN_RST && second_right_output_gain == `SOPC_GAIN_RST && right_inverter_bypass_out && !second_left_output_mute) else $error("bad reset values");
endmodule

bind sopc_regs sopc_regs_sva #(.ADDR_WIDTH(ADDR_WIDTH), .GAIN_WIDTH(GAIN_WIDTH),
  .BEEP_WIDTH(BEEP_WIDTH)) i_sopc_regs_sva (.mclk(mclk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .left_signal_sign(left_signal_sign), .right_signal_sign(right_signal_sign),
  .second_left_output_gain(second_left_output_gain),
  .second_left_output_mute(second_left_output_mute),
  .second_right_output_gain(second_right_output_gain),
  .second_right_output_mute(second_right_output_mute),
  .right_inverter_en_out(right_inverter_en_out),
  .right_inverter_bypass_out(right_inverter_bypass_out),
  .pair_ground_feedback_out(pair_ground_feedback_out),
  .beep_mix_out(beep_mix_out), .beep_gain_out(beep_gain_out));

// *** test_second_output_pair_control.sv ***
`timescale 1ns/1ps
`include "sopc_defs.vh"
// ==========================================================
// bench
module test_second_output_pair_control;
  localparam [9:0] A_OC = {`SOPC_IDX_OUTPUT_CONTROL, 2'b00};
  localparam [9:0] A_L = {`SOPC_IDX_LEFT2_VOLUME, 2'b00};
  localparam [9:0] A_R = {`SOPC_IDX_RIGHT2_VOLUME, 2'b00};
  localparam [9:0] A_B = {`SOPC_IDX_BEEP_VOLUME, 2'b00};
  localparam [9:0] A_ST = {`SOPC_IDX_PAIR_STATUS, 2'b00};
  reg mclk = 0;
  reg rst_n = 0;
  reg [9:0] avs_address = 10'h0;
  reg avs_read = 0;
  reg avs_write = 0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hf;
  reg left_sign = 0;
  reg right_sign = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [5:0] l_gain;
  wire [5:0] r_gain;
  wire [2:0] b_gain;
  wire l_mute, r_mute, inv_en, inv_byp, fb, bmix;
  int err_count = 0;
  int cmp_count = 0;
  integer seed = 94;
  logic [31:0] exp_q[$];
  reg [5:0] gl, gr;
  reg [2:0] gb;

  always #5 mclk = ~mclk;

  sopc_regs i_sopc_regs (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .left_signal_sign(left_sign),
    .right_signal_sign(right_sign), .second_left_output_gain(l_gain),
    .second_left_output_mute(l_mute), .second_right_output_gain(r_gain),
    .second_right_output_mute(r_mute), .right_inverter_en_out(inv_en),
    .right_inverter_bypass_out(inv_byp), .pair_ground_feedback_out(fb),
    .beep_mix_out(bmix), .beep_gain_out(b_gain));

  // ==========================================================
  // comparison, bus tasks, scoreboard
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // no cycle limit here: only the watchdog ends a hung access
  task wt;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
  endtask
  task wr(input [9:0] a, input [15:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= 1;
    wt();
    avs_write <= 0;
  endtask
  task rd(input [9:0] a, input [31:0] e);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1;
    exp_q.push_back(e);
    wt();
    avs_read <= 0;
  endtask
  task settle;
    repeat (6) @(posedge mclk);
  endtask
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0) chk("readdata", avs_readdata, exp_q.pop_front());
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // whole run is about two hundred cycles, far below the 20000-cycle watchdog
  initial begin
    #200000;
    err_count++;
    final_report();
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    rd(A_OC, 32'h0);
    rd(A_L, 32'he4);
    rd(A_R, 32'h2e4);
    rd(A_B, 32'h0);
    rd(A_ST, 32'h3939);
    rd(A_ST + 10'h4, 32'h0);
    wr(A_L + 10'h1, 16'h4000);
    rd(A_L + 10'h1, 32'h0);
    chk("left_mute", l_mute, 0);
    wr(A_OC, 16'hffff);
    rd(A_OC, 32'h4);
    chk("feedback", fb, 1);
    // software keeps inverting and non-inverting pairings only
    wr(A_R, 16'h0400);
    rd(A_R, 32'h400);
    chk("inverter", {inv_en, inv_byp}, 2'b10);
    wr(A_L, 16'h0054);
    settle();
    chk("left_gain", l_gain, 6'h39);
    for (int i = 0; i < 4; i++) begin
      gl = (i == 1) ? 6'h00 : (i == 2) ? 6'h3f : $random(seed);
      gr = $random(seed);
      gb = $random(seed);
      // beep is off before the right path leaves the inverting setting
      if (i[0]) begin
        wr(A_B, {8'h0, gb, 5'h0});
        wr(A_L, {8'h0, gl, 2'b00});
        wr(A_R, {5'h0, 3'b011, gr, 2'b00});
      end else begin
        wr(A_R, {5'h0, 3'b100, gr, 2'b00});
        wr(A_L, {8'h1, gl, 2'b00});
        wr(A_B, {i[1], 7'h0, gb, 5'h0});
      end
      settle();
      chk("left_gain", l_gain, gl);
      chk("right_gain", r_gain, gr);
      chk("beep", {bmix, b_gain}, {i[1] & ~i[0], gb});
      rd(A_L, {24'h0, gl, 2'b00});
      rd(A_ST, {16'h0, 2'b00, gr, 2'b00, gl});
    end
    // zero-cross deferral, then the sign flip releases it
    wr(A_L, {8'h61, 6'h2a, 2'b00});
    settle();
    chk("left_gain", l_gain, gl);
    rd(A_ST, {16'h0, 2'b01, gr, 2'b00, gl});
    chk("left_mute", l_mute, 1);
    left_sign <= 1;
    settle();
    chk("left_gain", l_gain, 6'h2a);
    for (int j = 0; j < 2; j++) begin
      wr(A_R, j ? 16'h4400 : 16'h4200);
      settle();
      chk("right_mute", {r_mute, inv_en, inv_byp}, {1'b1, j[0], ~j[0]});
    end
    // right channel deferral, path left inverting
    wr(A_R, {8'h65, 6'h15, 2'b00});
    settle();
    chk("right_gain", r_gain, gr);
    right_sign <= 1;
    settle();
    chk("right_gain", r_gain, 6'h15);
    // beep only once the inverting path is selected
    wr(A_B, 16'hffff);
    rd(A_B, 32'h80e0);
    final_report();
  end
endmodule
